// ===== hw/hsl_params.svh
// constants for the halfword signed load unit
`ifndef HSL_PARAMS_SVH
`define HSL_PARAMS_SVH

`define HSL_OP_DISP       6'h2a
`define HSL_OP_DISP_UPD   6'h2b
`define HSL_OP_EXT        6'h1f
`define HSL_XO_IDX        10'h157
`define HSL_XO_IDX_UPD    10'h177
`define HSL_GPR_COUNT     32

`endif

// ===== hw/hsl_pkg.sv
// types for the halfword signed load unit
package hsl_pkg;

	typedef enum logic [2:0]
	{
		HSL_NONE,
		HSL_DISP,
		HSL_DISP_UPD,
		HSL_IDX,
		HSL_IDX_UPD
	} hsl_form_type;

	typedef struct packed
	{
		logic [31:0] addr;
		logic        half;
	} hsl_req_type;

	typedef struct packed
	{
		logic [15:0] data;
		logic        align_exc;
		logic        dstor_exc;
	} hsl_rsp_type;

	typedef struct packed
	{
		logic [4:0]  target_reg_field;
		logic [4:0]  base_reg_field;
		logic [4:0]  index_reg_field;
		logic [15:0] disp;
	} hsl_fields_type;

endpackage : hsl_pkg

// ===== hw/hsl_unit.sv
// halfword signed load: decode, address, storage request, writeback
`timescale 1ns/100ps
`include "hsl_params.svh"

// Function
// - opcode 42 is plain displacement load, 43 the updating one
// - opcode 31 with extended 343 is plain indexed load
// - opcode 31 with extended 375 is updating indexed load
// - fetched halfword goes to low 16 bits of target register
// - halfword sign bit fills upper 16 bits of target
// - displacement address is base plus sign-extended displacement
// - base field zero: displacement alone is the address
// - indexed address is base plus index register
// - base field zero: index register alone is the address
// - update writes address to base if nonzero and not target
// - no base update after alignment or data storage exception
// - exception register and condition field 0 never touched
module hsl_unit
	import hsl_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// instruction issue
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr,
	output logic             instr_ready,
	output logic             instr_illegal,
	// storage access path
	output logic             mem_req_valid,
	output hsl_req_type      mem_req,
	input  wire logic        mem_rsp_valid,
	input  wire hsl_rsp_type mem_rsp,
	// completion
	output logic             done,
	output logic             exc_align,
	output logic             exc_dstor,
	// register file read port for inspection
	input  wire logic [4:0]  dbg_sel,
	output logic [31:0]      dbg_data
);

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_WAIT,
		ST_DONE
	} hsl_state_type;

	hsl_state_type  state;
	hsl_form_type   next_form;
	hsl_form_type   form;
	hsl_fields_type fld;
	logic [31:0]    gpr [`HSL_GPR_COUNT];
	logic [31:0]    next_ea;
	logic [31:0]    ea;
	logic [31:0]    sext_disp;
	logic [31:0]    base_val;
	logic [31:0]    index_val;
	logic           is_update;
	logic           upd_ok;
	logic [31:0]    loaded;

	// big-endian bit k of the word is instr[31-k]
	assign fld.target_reg_field = instr[25:21];
	assign fld.base_reg_field   = instr[20:16];
	assign fld.index_reg_field  = instr[15:11];
	assign fld.disp             = instr[15:0];

	// bit 31 (instr[0]) is reserved and not looked at
	always_comb
	begin
		next_form = HSL_NONE;
		unique case (instr[31:26])
			`HSL_OP_DISP:     next_form = HSL_DISP;
			`HSL_OP_DISP_UPD: next_form = HSL_DISP_UPD;
			`HSL_OP_EXT:
			begin
				if (instr[10:1] == `HSL_XO_IDX)
					next_form = HSL_IDX;
				else if (instr[10:1] == `HSL_XO_IDX_UPD)
					next_form = HSL_IDX_UPD;
			end
			default:          next_form = HSL_NONE;
		endcase
	end

	assign sext_disp = {{16{fld.disp[15]}}, fld.disp};
	// register 0 as base reads as zero, not its contents
	assign base_val  = (fld.base_reg_field == 5'h00) ? 32'h0000_0000
		: gpr[fld.base_reg_field];
	assign index_val = gpr[fld.index_reg_field];

	always_comb
	begin
		if (next_form == HSL_DISP || next_form == HSL_DISP_UPD)
			next_ea = base_val + sext_disp;
		else
			next_ea = base_val + index_val;
	end

	assign instr_ready   = (state == ST_IDLE);
	assign instr_illegal = instr_valid && instr_ready && (next_form == HSL_NONE);

	// one load in flight; the issue side stalls through the answer and the done cycle after it
	always_ff @(posedge core_clk)
	begin
		if (rst)
			state <= ST_IDLE;
		else
		begin
			unique case (state)
				ST_IDLE:
					if (instr_valid && next_form != HSL_NONE)
						state <= ST_WAIT;
				ST_WAIT:
					if (mem_rsp_valid)
						state <= ST_DONE;
				ST_DONE:
					state <= ST_IDLE;
			endcase
		end
	end

	// captured instruction context
	hsl_fields_type cap;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			form <= HSL_NONE;
			ea   <= 32'h0000_0000;
			cap  <= '0;
		end
		else if (state == ST_IDLE && instr_valid && next_form != HSL_NONE)
		begin
			form <= next_form;
			ea   <= next_ea;
			cap  <= fld;
		end
	end

	// request held steady while waiting
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			mem_req_valid <= 1'b0;
			mem_req       <= '0;
		end
		else if (state == ST_IDLE && instr_valid && next_form != HSL_NONE)
		begin
			mem_req_valid <= 1'b1;
			mem_req.addr  <= next_ea;
			mem_req.half  <= 1'b1;
		end
		else if (state == ST_WAIT && mem_rsp_valid)
		begin
			mem_req_valid <= 1'b0;
			mem_req.half  <= 1'b0;
		end
	end

	// data[15:8] is the lower-addressed byte
	assign loaded    = {{16{mem_rsp.data[15]}}, mem_rsp.data};
	assign is_update = (form == HSL_DISP_UPD) || (form == HSL_IDX_UPD);
	assign upd_ok    = is_update && (cap.base_reg_field != 5'h00)
		&& (cap.base_reg_field != cap.target_reg_field)
		&& !mem_rsp.align_exc && !mem_rsp.dstor_exc;

	// target written only when the access succeeded; no exception or
	// condition register is part of this unit, so none can change
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < `HSL_GPR_COUNT; i++)
				gpr[i] <= 32'h0000_0000;
		end
		else if (state == ST_WAIT && mem_rsp_valid)
		begin
			if (!mem_rsp.align_exc && !mem_rsp.dstor_exc)
				gpr[cap.target_reg_field] <= loaded;
			if (upd_ok)
				gpr[cap.base_reg_field] <= ea;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			done      <= 1'b0;
			exc_align <= 1'b0;
			exc_dstor <= 1'b0;
		end
		else
		begin
			done      <= (state == ST_WAIT) && mem_rsp_valid;
			exc_align <= (state == ST_WAIT) && mem_rsp_valid && mem_rsp.align_exc;
			exc_dstor <= (state == ST_WAIT) && mem_rsp_valid && mem_rsp.dstor_exc;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			dbg_data <= 32'h0000_0000;
		else
			dbg_data <= gpr[dbg_sel];
	end

	// checks
	sequence s_rsp_ok;
		state == ST_WAIT && mem_rsp_valid && !mem_rsp.align_exc && !mem_rsp.dstor_exc;
	endsequence

	sequence s_rsp_bad;
		state == ST_WAIT && mem_rsp_valid && (mem_rsp.align_exc || mem_rsp.dstor_exc);
	endsequence

	property p_disp_decode;
		@(posedge core_clk) disable iff (rst)
		(instr[31:26] == `HSL_OP_DISP) |-> next_form == HSL_DISP;
	endproperty
	a_disp_decode: assert property (p_disp_decode)
		else $error("opcode 42 not decoded");

	property p_idx_decode;
		@(posedge core_clk) disable iff (rst)
		(instr[31:26] == `HSL_OP_EXT && instr[10:1] == `HSL_XO_IDX) |-> next_form == HSL_IDX;
	endproperty
	a_idx_decode: assert property (p_idx_decode)
		else $error("indexed form not decoded");

	property p_idxu_decode;
		@(posedge core_clk) disable iff (rst)
		(instr[31:26] == `HSL_OP_EXT && instr[10:1] == `HSL_XO_IDX_UPD)
			|-> next_form == HSL_IDX_UPD;
	endproperty
	a_idxu_decode: assert property (p_idxu_decode)
		else $error("updating indexed form not decoded");

	property p_req_addr;
		@(posedge core_clk) disable iff (rst)
		(state == ST_IDLE && instr_valid && next_form != HSL_NONE)
			|=> mem_req_valid && mem_req.addr == $past(next_ea) && mem_req.half;
	endproperty
	a_req_addr: assert property (p_req_addr)
		else $error("storage request wrong");

	property p_disp_zero_base;
		@(posedge core_clk) disable iff (rst)
		(next_form == HSL_DISP && fld.base_reg_field == 5'h00) |-> next_ea == sext_disp;
	endproperty
	a_disp_zero_base: assert property (p_disp_zero_base)
		else $error("zero base not ignored");

	property p_idx_zero_base;
		@(posedge core_clk) disable iff (rst)
		(next_form == HSL_IDX && fld.base_reg_field == 5'h00) |-> next_ea == index_val;
	endproperty
	a_idx_zero_base: assert property (p_idx_zero_base)
		else $error("indexed zero base wrong");

	property p_sext_result;
		logic [4:0] t;
		logic [15:0] d;
		@(posedge core_clk) disable iff (rst)
		(s_rsp_ok, t = cap.target_reg_field, d = mem_rsp.data)
			##2 (dbg_sel == t) |-> ##1 (dbg_data == {{16{d[15]}}, d});
	endproperty
	a_sext_result: assert property (p_sext_result)
		else $error("sign extension wrong");

	property p_no_upd_on_exc;
		logic [4:0] b;
		logic [31:0] v;
		@(posedge core_clk) disable iff (rst)
		(s_rsp_bad, b = cap.base_reg_field, v = gpr[cap.base_reg_field])
			|=> gpr[b] == v;
	endproperty
	a_no_upd_on_exc: assert property (p_no_upd_on_exc)
		else $error("base updated after exception");

	property p_upd_base;
		logic [4:0] b;
		logic [31:0] a;
		@(posedge core_clk) disable iff (rst)
		(s_rsp_ok ##0 (is_update && cap.base_reg_field != 5'h00
			&& cap.base_reg_field != cap.target_reg_field),
			b = cap.base_reg_field, a = ea) |=> gpr[b] == a;
	endproperty
	a_upd_base: assert property (p_upd_base)
		else $error("base not updated with address");

endmodule : hsl_unit

// ===== tb/hsl_mem_model.sv
// storage model answering halfword reads after a chosen wait
`timescale 1ns/100ps
module hsl_mem_model
	import hsl_pkg::*;
(
	// clock
	input  wire logic        core_clk,
	// request from the unit
	input  wire logic        mem_req_valid,
	input  wire hsl_req_type mem_req,
	// answer to the unit
	output logic             mem_rsp_valid,
	output hsl_rsp_type      mem_rsp,
	// answer set by the scenario
	input  wire logic [15:0] rsp_data,
	input  wire logic [1:0]  rsp_exc,
	input  wire logic [3:0]  rsp_wait
);
	logic [3:0] cnt;

	// single driver: the idle branch settles valid and the exception lines at the first edge; data stays unknown until the first answer
	always @(posedge core_clk)
	begin
		if (mem_req_valid && mem_req.half && !mem_rsp_valid && cnt == rsp_wait)
		begin
			mem_rsp_valid <= 1'b1;
			mem_rsp <= {rsp_data, rsp_exc};
			cnt <= 4'h0;
		end
		else
		begin
			// released lines must not keep the last value
			mem_rsp_valid <= 1'b0;
			mem_rsp <= {~mem_rsp.data, 2'b00};
			cnt <= (mem_req_valid && !mem_rsp_valid) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule : hsl_mem_model

// ===== tb/tb_halfword_signed_load_unit.sv
// testbench for the halfword signed load unit
`timescale 1ns/100ps
module tb_halfword_signed_load_unit
	import hsl_pkg::*;
;
	logic        core_clk;
	logic        rst;
	logic        instr_valid;
	logic [31:0] instr;
	logic        instr_ready;
	logic        instr_illegal;
	logic        mem_req_valid;
	hsl_req_type mem_req;
	logic        mem_rsp_valid;
	hsl_rsp_type mem_rsp;
	logic        done;
	logic        exc_align;
	logic        exc_dstor;
	logic [4:0]  dbg_sel;
	logic [31:0] dbg_data;
	logic [15:0] rsp_data;
	logic [1:0]  rsp_exc;
	logic [3:0]  rsp_wait;
	int          fail_count;
	int          compares;

	hsl_unit u_hsl_unit (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
		.instr(instr), .instr_ready(instr_ready), .instr_illegal(instr_illegal),
		.mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_rsp_valid(mem_rsp_valid),
		.mem_rsp(mem_rsp), .done(done), .exc_align(exc_align), .exc_dstor(exc_dstor),
		.dbg_sel(dbg_sel), .dbg_data(dbg_data));

	hsl_mem_model u_hsl_mem_model (.core_clk(core_clk), .mem_req_valid(mem_req_valid),
		.mem_req(mem_req), .mem_rsp_valid(mem_rsp_valid), .mem_rsp(mem_rsp),
		.rsp_data(rsp_data), .rsp_exc(rsp_exc), .rsp_wait(rsp_wait));

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task results;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask : chk

	// waits on a design output, giving up after a bounded count
	task wait_hi(input int which);
		int n;
		for (n = 0; n < 30; n++)
		begin
			if ((which == 0 ? mem_req_valid : done) === 1'b1)
				break;
			@(posedge core_clk);
			#1;
		end
		if (n == 30)
		begin
			chk("timeout", 32'h1, 32'h0);
			results();
		end
	endtask : wait_hi

	task ld(input logic [31:0] ins, input logic [15:0] d, input logic [1:0] e,
		input logic [31:0] ea);
		@(posedge core_clk);
		rsp_data <= d;
		rsp_exc <= e;
		instr <= ins;
		instr_valid <= 1'b1;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		wait_hi(0);
		chk("addr", ea, mem_req.addr);
		chk("half", 32'h1, {31'h0, mem_req.half});
		chk("busy", 32'h0, {31'h0, instr_ready});
		wait_hi(1);
		chk("exc", {30'h0, e}, {30'h0, exc_align, exc_dstor});
	endtask : ld

	task gpr(input logic [4:0] s, input logic [31:0] exp);
		@(posedge core_clk);
		dbg_sel <= s;
		#1;
		chk("idle", 32'h4, {29'h0, instr_ready, done, mem_req_valid});
		@(posedge core_clk);
		@(posedge core_clk);
		#1;
		chk("gpr", exp, dbg_data);
	endtask : gpr

	task illegal(input logic [31:0] ins);
		@(posedge core_clk);
		instr <= ins;
		instr_valid <= 1'b1;
		#1;
		chk("illegal", 32'h1, {31'h0, instr_illegal});
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		chk("no_req", 32'h0, {31'h0, mem_req_valid});
	endtask : illegal

	initial
	begin
		fail_count = 0;
		compares = 0;
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = 32'h0;
		dbg_sel = 5'h0;
		rsp_data = 16'h0;
		rsp_exc = 2'h0;
		rsp_wait = 4'h0;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk("reset", 32'h4, {29'h0, instr_ready, done, mem_req_valid});
		chk("dbg_reset", 32'h0, dbg_data);
		ld({6'h2a, 5'd1, 5'd0, 16'h8000}, 16'h1234, 2'h0, 32'hffff8000);
		gpr(5'd1, 32'h00001234);
		ld({6'h2a, 5'd2, 5'd0, 16'h0010}, 16'h8001, 2'h0, 32'h00000010);
		gpr(5'd2, 32'hffff8001);
		ld({6'h2a, 5'd3, 5'd1, 16'hfffe}, 16'h7fff, 2'h0, 32'h00001232);
		gpr(5'd3, 32'h00007fff);
		rsp_wait <= 4'h3;
		ld({6'h2b, 5'd4, 5'd1, 16'h0002}, 16'hffff, 2'h0, 32'h00001236);
		gpr(5'd1, 32'h00001236);
		ld({6'h1f, 5'd5, 5'd1, 5'd2, 10'h157, 1'b1}, 16'h0001, 2'h0, 32'hffff9237);
		gpr(5'd5, 32'h00000001);
		ld({6'h1f, 5'd7, 5'd0, 5'd1, 10'h157, 1'b0}, 16'h8000, 2'h0, 32'h00001236);
		gpr(5'd7, 32'hffff8000);
		ld({6'h1f, 5'd6, 5'd2, 5'd1, 10'h177, 1'b0}, 16'h0005, 2'h2, 32'hffff9237);
		gpr(5'd2, 32'hffff8001);
		ld({6'h2b, 5'd6, 5'd1, 16'h0010}, 16'h0005, 2'h1, 32'h00001246);
		gpr(5'd1, 32'h00001236);
		gpr(5'd6, 32'h00000000);
		rsp_wait <= 4'h0;
		ld({6'h2b, 5'd8, 5'd0, 16'h0004}, 16'h0003, 2'h0, 32'h00000004);
		gpr(5'd0, 32'h00000000);
		ld({6'h1f, 5'd2, 5'd2, 5'd1, 10'h177, 1'b0}, 16'h4321, 2'h0, 32'hffff9237);
		gpr(5'd2, 32'h00004321);
		ld({6'h1f, 5'd6, 5'd2, 5'd1, 10'h177, 1'b0}, 16'h0102, 2'h0, 32'h00005557);
		gpr(5'd6, 32'h00000102);
		gpr(5'd2, 32'h00005557);
		illegal({6'h1f, 5'd3, 5'd1, 5'd2, 10'h14b, 1'b0});
		illegal({6'h28, 5'd3, 5'd1, 16'h0000});
		gpr(5'd3, 32'h00007fff);
		results();
	end
endmodule : tb_halfword_signed_load_unit
